// ---- hw/pump_run_regs.svh ----
// register offsets, field positions, reset values and timing counts of the run control
`ifndef PUMP_RUN_REGS_SVH
`define PUMP_RUN_REGS_SVH
// What this block does
// - stopping a running program early pauses it and blinks the pumping indicator
// - start while paused resumes the same phase, volume target kept from phase start
// - any non-start key while paused cancels pause; next start is phase 1
// - stall stops motor, pauses, raises alarm, blinks indicator, steady buzzer if enabled
// - with serial safe mode, a stall sends an alarm message to the host
// - any key press silences the buzzer and clears the alarm
// - after a stall, start from keypad, trigger input or serial resumes
// - setup only while stopped; advances after 2 s idle or a non-arrow key
// - setup order: power fail, alarm, io, trigger, direction, motor out, lock, beep, addr, baud
// - power-fail restart 1 never restarts: setup is still 0 in the one cycle after reset where it is checked
// - alarms on: beeping at end or while paused, steady tone on alarm
// - trigger modes: toggle on fall; level stop fall, start rise; start only on fall
// - direction modes: reciprocating fall infuse rise withdraw; dual pump reversed
// - motor output mode 0 is high only while the motor runs
// - motor output mode 1 is high for as long as the program is running, in any phase
// - keypad lockout rejects rate and direction keys while executing
// - key beep gives one short beep for every key press
// - network address is 00 to 99, default 00
// - baud selectable among 300, 1200, 2400, 9600, 19200; host must match
// - every start from stopped begins at phase 1; each finished pumping phase goes to the next
// - some phase functions jump to another phase, some conditionally on events
// - each phase holds one control or pumping function with volume and direction; rate is one separate register
// - program store holds phases up to maximum phase 41
// - advancing past the maximum phase behaves as a stop and ends the program
// - pumping phase with nonzero volume ends when that volume moved since phase start
`define ADR_CTRL 4'h0
`define ADR_SETUP 4'h1
`define ADR_STATUS 4'h2
`define ADR_PHASE_SEL 4'h3
`define ADR_PHASE_DATA 4'h4
`define ADR_RATE 4'h5
`define ADR_EVENT 4'h6
`define ADR_MOVED 4'h7
`define CTRL_START 0
`define CTRL_STOP 1
`define CTRL_SAFE 2
`define CTRL_STALL_ACK 3
`define SET_PF 0
`define SET_ALARM 1
`define SET_TRIG_LO 2
`define SET_DIR_LO 4
`define SET_MOUT 5
`define SET_LOCK 6
`define SET_BEEP 7
`define SET_ADDR_LO 8
`define SET_BAUD_LO 16
`define SETUP_RESET 32'h0000_0000
`define MAX_PHASE 6'd41
`define SETUP_IDLE_MS 2000
`define BEEP_MS 50
`define BLINK_MS 250
`define DEBOUNCE_US 1000
`define CLK_KHZ 25000
`define SETUP_IDLE_CYC (`SETUP_IDLE_MS * `CLK_KHZ)
`define BEEP_CYC (`BEEP_MS * `CLK_KHZ)
`define BLINK_CYC (`BLINK_MS * `CLK_KHZ)
`define DEBOUNCE_CYC ((`DEBOUNCE_US * `CLK_KHZ) / 1000)
`endif

// ---- hw/pump_run_pkg.sv ----
// types of the pump run control
package pump_run_pkg;
    typedef enum logic [1:0] {
        RUN_STOPPED = 2'b00,
        RUN_RUNNING = 2'b01,
        RUN_PAUSED = 2'b11
    } run_state_t;
    typedef enum logic [1:0] {
        FN_RATE = 2'h0,
        FN_STOP = 2'h1,
        FN_JUMP = 2'h2,
        FN_WAIT = 2'h3
    } phase_fn_t;
    typedef enum logic [3:0] {
        SU_POWER_FAIL = 4'h0,
        SU_ALARM = 4'h1,
        SU_IO = 4'h2,
        SU_TRIGGER = 4'h3,
        SU_DIRECTION = 4'h4,
        SU_MOTOR_OUT = 4'h5,
        SU_LOCKOUT = 4'h6,
        SU_KEY_BEEP = 4'h7,
        SU_ADDRESS = 4'h8,
        SU_BAUD = 4'h9,
        SU_OFF = 4'hf
    } setup_item_t;
    typedef enum logic [1:0] {
        toggle_trigger_mode = 2'h0,
        level_trigger_mode = 2'h1,
        start_only_trigger_mode = 2'h2
    } trig_mode_t;
endpackage : pump_run_pkg

// ---- hw/pump_program_run_control.sv ----
// run control of the programmable pump sequencer with its wishbone register file
`timescale 1ns/1ns
`default_nettype none
`include "pump_run_regs.svh"
module pump_program_run_control
    import pump_run_pkg::*;
#(
    parameter int SETUP_IDLE_CYCLES = `SETUP_IDLE_CYC,
    parameter int BEEP_CYCLES = `BEEP_CYC,
    parameter int BLINK_CYCLES = `BLINK_CYC,
    parameter int DEBOUNCE_CYCLES = `DEBOUNCE_CYC,
    parameter int PHASES = 41
) (
    // clock and reset
    input wire logic clock_in,
    input wire logic rst_n_in,
    // wishbone slave
    input wire logic wb_cyc_in,
    input wire logic wb_stb_in,
    input wire logic wb_we_in,
    input wire logic [5:0] wb_adr_in,
    input wire logic [3:0] wb_sel_in,
    input wire logic [31:0] wb_dat_in,
    output logic [31:0] wb_dat_out,
    output logic wb_ack_out,
    // keypad
    input wire logic key_press_in,
    input wire logic key_start_in,
    input wire logic key_arrow_in,
    input wire logic key_rate_dir_in,
    input wire logic key_held_in,
    output logic key_accept_out,
    // motor and sensors
    input wire logic stall_in,
    input wire logic volume_step_in,
    input wire logic power_was_running_in,
    output logic motor_run_out,
    output logic motor_withdraw_out,
    // ttl io
    input wire logic trigger_in,
    input wire logic direction_in,
    output logic motor_operating_out,
    // indicators and serial
    output logic pumping_led_out,
    output logic buzzer_out,
    output logic alarm_msg_out,
    output logic [3:0] setup_item_out,
    output logic [5:0] phase_out
);
    // ****************************************
    // parameter checks
    // ****************************************
    initial begin
        if (PHASES < 1 || PHASES > 63) begin
            $error("phase count out of range");
        end
        if (DEBOUNCE_CYCLES < 1 || BEEP_CYCLES < 1 || BLINK_CYCLES < 1) begin
            $error("timing counts must be at least one");
        end
    end
    // ****************************************
    // registers and program store
    // ****************************************
    run_state_t run_reg;
    logic [31:0] setup_reg;
    logic safe_reg;
    logic stall_alarm_reg;
    logic [5:0] phase_reg;
    logic [5:0] sel_reg;
    logic [15:0] moved_reg;
    logic [15:0] rate_reg;
    logic ended_reg;
    logic [31:0] prog_mem [1:PHASES];
    logic wb_req;
    logic wb_wr;
    logic [3:0] wb_idx;
    logic trig_event;
    logic trig_start;
    logic trig_stop;
    logic key_other;
    logic start_req;
    logic stop_req;
    logic [31:0] cur_entry;
    phase_fn_t cur_fn;
    logic phase_done;
    logic [5:0] next_phase;
    logic dir_fall;
    logic dir_rise;
    logic boot_done_reg;
    logic power_restart;
    assign wb_req = wb_cyc_in && wb_stb_in && !wb_ack_out;
    assign wb_wr = wb_req && wb_we_in;
    assign wb_idx = wb_adr_in[5:2];
    // ****************************************
    // input synchronise, debounce and edges
    // ****************************************
    logic [1:0] pin_raw;
    logic [1:0] pin_stable;
    logic [1:0] pin_prev;
    logic [1:0] pin_fall;
    logic [1:0] pin_rise;
    assign pin_raw = {direction_in, trigger_in};
    generate
        for (genvar i = 0; i < 2; i++) begin : g_pin
            logic sync1_reg;
            logic sync2_reg;
            logic [23:0] db_cnt_reg;
            logic stable_reg;
            logic prev_reg;
            always_ff @(posedge clock_in or negedge rst_n_in) begin
                if (!rst_n_in) begin
                    sync1_reg <= 1'b1;
                    sync2_reg <= 1'b1;
                end else begin
                    sync1_reg <= pin_raw[i];
                    sync2_reg <= sync1_reg;
                end
            end
            always_ff @(posedge clock_in or negedge rst_n_in) begin
                if (!rst_n_in) begin
                    db_cnt_reg <= 24'h00_0000;
                    stable_reg <= 1'b1;
                    prev_reg <= 1'b1;
                end else begin
                    prev_reg <= stable_reg;
                    if (sync2_reg == stable_reg) begin
                        db_cnt_reg <= 24'h00_0000;
                    end else if (db_cnt_reg >= 24'(DEBOUNCE_CYCLES - 1)) begin
                        db_cnt_reg <= 24'h00_0000;
                        stable_reg <= sync2_reg;
                    end else begin
                        db_cnt_reg <= db_cnt_reg + 24'h00_0001;
                    end
                end
            end
            assign pin_stable[i] = stable_reg;
            assign pin_prev[i] = prev_reg;
            assign pin_fall[i] = prev_reg && !stable_reg;
            assign pin_rise[i] = !prev_reg && stable_reg;
        end
    endgenerate
    assign dir_fall = pin_fall[1];
    assign dir_rise = pin_rise[1];
    // ****************************************
    // start and stop sources
    // ****************************************
    always_comb begin
        trig_start = 1'b0;
        trig_stop = 1'b0;
        case (trig_mode_t'(setup_reg[`SET_TRIG_LO +: 2]))
            toggle_trigger_mode: begin
                trig_start = pin_fall[0] && run_reg != RUN_RUNNING;
                trig_stop = pin_fall[0] && run_reg == RUN_RUNNING;
            end
            level_trigger_mode: begin
                trig_stop = pin_fall[0];
                trig_start = pin_rise[0];
            end
            start_only_trigger_mode: begin
                trig_start = pin_fall[0];
            end
            default: begin
                trig_start = 1'b0;
            end
        endcase
    end
    assign trig_event = trig_start || trig_stop;
    assign key_other = key_press_in && !key_start_in;
    // keypad start toggles, serial and trigger start from any source
    assign start_req = (key_press_in && key_start_in && run_reg != RUN_RUNNING) || trig_start
        || (wb_wr && wb_idx == `ADR_CTRL && wb_sel_in[0] && wb_dat_in[`CTRL_START]);
    assign stop_req = (key_press_in && key_start_in && run_reg == RUN_RUNNING) || trig_stop
        || (wb_wr && wb_idx == `ADR_CTRL && wb_sel_in[0] && wb_dat_in[`CTRL_STOP]);
    // ****************************************
    // phase sequencing
    // ****************************************
    assign cur_entry = prog_mem[phase_reg];
    assign cur_fn = phase_fn_t'(cur_entry[31:30]);
    always_comb begin
        phase_done = 1'b0;
        next_phase = phase_reg + 6'd1;
        case (cur_fn)
            FN_RATE: begin
                phase_done = cur_entry[15:0] != 16'h0000
                    && moved_reg >= cur_entry[15:0];
            end
            FN_JUMP: begin
                phase_done = 1'b1;
                next_phase = cur_entry[5:0];
            end
            FN_WAIT: begin
                phase_done = trig_event;
                next_phase = trig_event ? cur_entry[5:0] : phase_reg + 6'd1;
            end
            default: begin
                phase_done = 1'b0;
            end
        endcase
    end
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            run_reg <= RUN_STOPPED;
            phase_reg <= 6'd1;
            moved_reg <= 16'h0000;
            ended_reg <= 1'b0;
        end else if (run_reg == RUN_RUNNING) begin
            if (stall_in || stop_req) begin
                run_reg <= RUN_PAUSED;
            end else if (cur_fn == FN_STOP || (phase_done
                    && (next_phase > `MAX_PHASE || next_phase > 6'(PHASES)
                    || next_phase == 6'd0))) begin
                run_reg <= RUN_STOPPED;
                phase_reg <= 6'd1;
                ended_reg <= 1'b1;
            end else if (phase_done) begin
                phase_reg <= next_phase;
                moved_reg <= 16'h0000;
            end else if (volume_step_in && cur_fn == FN_RATE) begin
                moved_reg <= moved_reg + 16'h0001;
            end
        end else if (run_reg == RUN_PAUSED && start_req) begin
            run_reg <= RUN_RUNNING;
        end else if (run_reg == RUN_PAUSED && key_other) begin
            run_reg <= RUN_STOPPED;
            phase_reg <= 6'd1;
        end else if (start_req || power_restart) begin
            run_reg <= RUN_RUNNING;
            phase_reg <= 6'd1;
            moved_reg <= 16'h0000;
            ended_reg <= 1'b0;
        end else if (key_press_in) begin
            ended_reg <= 1'b0;
        end
    end
    // ****************************************
    // power fail restart, caught after reset release
    // ****************************************
    assign power_restart = !boot_done_reg && setup_reg[`SET_PF] && power_was_running_in
        && !key_held_in;
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            boot_done_reg <= 1'b0;
        end else begin
            boot_done_reg <= 1'b1;
        end
    end
    // ****************************************
    // stall alarm and serial message
    // ****************************************
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            stall_alarm_reg <= 1'b0;
            alarm_msg_out <= 1'b0;
        end else begin
            alarm_msg_out <= run_reg == RUN_RUNNING && stall_in && safe_reg;
            if (run_reg == RUN_RUNNING && stall_in) begin
                stall_alarm_reg <= 1'b1;
            end else if (key_press_in || (wb_wr && wb_idx == `ADR_CTRL && wb_sel_in[0]
                    && wb_dat_in[`CTRL_STALL_ACK])) begin
                stall_alarm_reg <= 1'b0;
            end
        end
    end
    // ****************************************
    // buzzer, blink and key beep
    // ****************************************
    logic [26:0] blink_cnt_reg;
    logic blink_reg;
    logic [26:0] beep_cnt_reg;
    logic chirp_silenced_reg;
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            blink_cnt_reg <= 27'h000_0000;
            blink_reg <= 1'b0;
        end else if (blink_cnt_reg >= 27'(BLINK_CYCLES - 1)) begin
            blink_cnt_reg <= 27'h000_0000;
            blink_reg <= !blink_reg;
        end else begin
            blink_cnt_reg <= blink_cnt_reg + 27'h000_0001;
        end
    end
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            beep_cnt_reg <= 27'h000_0000;
        end else if (key_press_in && setup_reg[`SET_BEEP]) begin
            beep_cnt_reg <= 27'(BEEP_CYCLES);
        end else if (beep_cnt_reg != 27'h000_0000) begin
            beep_cnt_reg <= beep_cnt_reg - 27'h000_0001;
        end
    end
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            chirp_silenced_reg <= 1'b0;
        end else if (start_req) begin
            chirp_silenced_reg <= 1'b0;
        end else if (key_press_in) begin
            chirp_silenced_reg <= 1'b1;
        end
    end
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            buzzer_out <= 1'b0;
            pumping_led_out <= 1'b0;
        end else begin
            pumping_led_out <= run_reg == RUN_RUNNING
                || (run_reg == RUN_PAUSED && blink_reg);
            if (setup_reg[`SET_ALARM] && stall_alarm_reg) begin
                buzzer_out <= 1'b1;
            end else if (setup_reg[`SET_ALARM] && !chirp_silenced_reg
                    && (ended_reg || run_reg == RUN_PAUSED)) begin
                buzzer_out <= blink_reg;
            end else begin
                buzzer_out <= beep_cnt_reg != 27'h000_0000;
            end
        end
    end
    // ****************************************
    // motor outputs
    // ****************************************
    logic motor_on;
    assign motor_on = run_reg == RUN_RUNNING && cur_fn == FN_RATE && !stall_in;
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            motor_run_out <= 1'b0;
            motor_operating_out <= 1'b0;
            motor_withdraw_out <= 1'b0;
        end else begin
            motor_run_out <= motor_on;
            if (setup_reg[`SET_MOUT]) begin
                motor_operating_out <= run_reg == RUN_RUNNING;
            end else begin
                motor_operating_out <= motor_on;
            end
            if (dir_fall) begin
                motor_withdraw_out <= setup_reg[`SET_DIR_LO];
            end else if (dir_rise) begin
                motor_withdraw_out <= !setup_reg[`SET_DIR_LO];
            end else if (phase_done || start_req) begin
                motor_withdraw_out <= prog_mem[start_req ? 6'd1 : next_phase][29];
            end
        end
    end
    // ****************************************
    // setup walk
    // ****************************************
    setup_item_t item_reg;
    logic [26:0] idle_cnt_reg;
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            item_reg <= SU_OFF;
            idle_cnt_reg <= 27'h000_0000;
        end else if (run_reg != RUN_STOPPED) begin
            item_reg <= SU_OFF;
        end else if (item_reg == SU_OFF) begin
            if (wb_wr && wb_idx == `ADR_SETUP) begin
                item_reg <= SU_POWER_FAIL;
                idle_cnt_reg <= 27'h000_0000;
            end
        end else if (key_press_in && key_arrow_in) begin
            idle_cnt_reg <= 27'h000_0000;
        end else if (key_press_in || idle_cnt_reg >= 27'(SETUP_IDLE_CYCLES - 1)) begin
            idle_cnt_reg <= 27'h000_0000;
            item_reg <= item_reg == SU_BAUD ? SU_OFF
                : setup_item_t'(item_reg + 4'h1);
        end else begin
            idle_cnt_reg <= idle_cnt_reg + 27'h000_0001;
        end
    end
    assign setup_item_out = item_reg;
    assign phase_out = phase_reg;
    assign key_accept_out = !(setup_reg[`SET_LOCK] && run_reg == RUN_RUNNING
        && key_rate_dir_in);
    // ****************************************
    // wishbone register file
    // ****************************************
    logic [31:0] setup_wr;
    always_comb begin
        setup_wr = setup_reg;
        for (int b = 0; b < 4; b++) begin
            if (wb_sel_in[b]) begin
                setup_wr[b*8 +: 8] = wb_dat_in[b*8 +: 8];
            end
        end
    end
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            setup_reg <= `SETUP_RESET;
            safe_reg <= 1'b0;
            sel_reg <= 6'd1;
            rate_reg <= 16'h0000;
        end else if (wb_wr) begin
            case (wb_idx)
                `ADR_SETUP: begin
                    if (run_reg == RUN_STOPPED && setup_wr[`SET_ADDR_LO +: 8] <= 8'd99
                            && setup_wr[`SET_BAUD_LO +: 3] <= 3'd4
                            && setup_wr[`SET_TRIG_LO +: 2] != 2'h3) begin
                        setup_reg <= setup_wr;
                    end
                end
                `ADR_CTRL: safe_reg <= wb_sel_in[0] ? wb_dat_in[`CTRL_SAFE] : safe_reg;
                `ADR_PHASE_SEL: begin
                    if (wb_dat_in[5:0] >= 6'd1 && wb_dat_in[5:0] <= 6'(PHASES)) begin
                        sel_reg <= wb_dat_in[5:0];
                    end
                end
                `ADR_RATE: rate_reg <= wb_dat_in[15:0];
                default: sel_reg <= sel_reg;
            endcase
        end
    end
    generate
        for (genvar p = 1; p <= PHASES; p++) begin : g_phase
            always_ff @(posedge clock_in or negedge rst_n_in) begin
                if (!rst_n_in) begin
                    prog_mem[p] <= 32'h4000_0000;
                end else if (wb_wr && wb_idx == `ADR_PHASE_DATA && sel_reg == 6'(p)
                        && run_reg == RUN_STOPPED) begin
                    prog_mem[p] <= wb_dat_in;
                end
            end
        end
    endgenerate
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wb_ack_out <= 1'b0;
            wb_dat_out <= 32'h0000_0000;
        end else begin
            wb_ack_out <= wb_req;
            case (wb_idx)
                `ADR_CTRL: wb_dat_out <= {29'h0, safe_reg, 2'h0};
                `ADR_SETUP: wb_dat_out <= setup_reg;
                `ADR_STATUS: wb_dat_out <= {16'h0, 2'h0, phase_reg, 2'h0, pin_stable,
                    ended_reg, stall_alarm_reg, run_reg};
                `ADR_PHASE_SEL: wb_dat_out <= {26'h0, sel_reg};
                `ADR_PHASE_DATA: wb_dat_out <= prog_mem[sel_reg];
                `ADR_RATE: wb_dat_out <= {16'h0, rate_reg};
                `ADR_EVENT: wb_dat_out <= {28'h0, pin_prev, pin_stable};
                `ADR_MOVED: wb_dat_out <= {16'h0, moved_reg};
                default: wb_dat_out <= 32'h0000_0000;
            endcase
        end
    end
endmodule : pump_program_run_control
`default_nettype wire

// ---- tb/ttl_far_model.sv ----
// external ttl equipment driving trigger and direction lines
`timescale 1ns/1ns
`default_nettype none
module ttl_far_model (
    // bench command and clock
    input wire logic clock_in,
    input wire logic [1:0] go_in,
    // ttl lines, idle high
    output logic [1:0] line_out
);
    logic [3:0] cnt_reg [2] = '{4'h0, 4'h0};
    // each command gives a falling then a rising edge, low 8 cycles
    always_ff @(posedge clock_in) begin
        for (int i = 0; i < 2; i++) begin
            cnt_reg[i] <= go_in[i] ? 4'h8 : cnt_reg[i] - {3'h0, cnt_reg[i] != 4'h0};
        end
    end
    assign line_out = {cnt_reg[1] == 4'h0, cnt_reg[0] == 4'h0};
endmodule : ttl_far_model
`default_nettype wire

// ---- tb/pump_run_chk.sv ----
// port assertions of the pump run control
`timescale 1ns/1ns
`default_nettype none
module pump_run_chk (
    // watched ports
    input wire logic clock_in,
    input wire logic rst_n_in,
    input wire logic wb_cyc_in,
    input wire logic wb_stb_in,
    input wire logic wb_ack_out,
    input wire logic stall_in,
    input wire logic motor_run_out,
    input wire logic motor_operating_out,
    input wire logic alarm_msg_out
);
    default clocking @(posedge clock_in); endclocking
    default disable iff (!rst_n_in);
    sequence req_s; wb_cyc_in && wb_stb_in && !wb_ack_out; endsequence
    sequence stall_s; stall_in ##1 stall_in; endsequence
    ack_next_a: assert property (req_s |=> wb_ack_out) else $error("ack late");
    ack_cause_a: assert property (wb_ack_out |-> $past(wb_cyc_in && wb_stb_in))
        else $error("ack without request");
    ack_drop_a: assert property (wb_ack_out |=> !wb_ack_out) else $error("ack too long");
    stall_stop_a: assert property ($rose(stall_in) |=> !motor_run_out)
        else $error("motor runs on stall");
    stall_hold_a: assert property (stall_s |-> !motor_run_out)
        else $error("motor runs while stalled");
    msg_cause_a: assert property (alarm_msg_out |-> $past(stall_in))
        else $error("alarm message without stall");
    msg_pulse_a: assert property (alarm_msg_out |=> !alarm_msg_out)
        else $error("alarm message too long");
    oper_run_a: assert property (motor_run_out |-> ##[0:1] motor_operating_out)
        else $error("operating output low while motor runs");
endmodule : pump_run_chk
bind pump_program_run_control pump_run_chk chk (.clock_in(clock_in), .rst_n_in(rst_n_in),
    .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in), .wb_ack_out(wb_ack_out),
    .stall_in(stall_in), .motor_run_out(motor_run_out),
    .motor_operating_out(motor_operating_out), .alarm_msg_out(alarm_msg_out));
`default_nettype wire

// ---- tb/testbench.sv ----
// self-checking bench of the pump run control
`timescale 1ns/1ns
`default_nettype none
`include "pump_run_regs.svh"
module testbench;
    logic clock_in = 1'h0, rst_n = 1'h0, cyc = 1'h0, wr = 1'h0, kp = 1'h0, ks = 1'h0;
    logic stall = 1'h0, vol = 1'h0;
    logic [5:0] adr = 6'h0;
    logic [31:0] dat = 32'h0, rdat, ad;
    logic [1:0] go = 2'h0, ttl;
    logic ack;
    logic rd = 1'h1, mrun, mop, amsg, buz, led, kacc, mwd;
    logic [5:0] ph;
    logic [3:0] item;
    wire [16:0] o = {ph, item, kacc, mwd, led, buz, amsg, mop, mrun};
    logic [63:0] exp_q[$], e;
    int n_errors = 0, n_tests = 0, seed = 32'h36fe, cycles = 0;
    always #20 clock_in = ~clock_in;
    ttl_far_model far (.clock_in(clock_in), .go_in(go), .line_out(ttl));
    pump_program_run_control #(.SETUP_IDLE_CYCLES(8), .BEEP_CYCLES(3), .BLINK_CYCLES(4),
        .DEBOUNCE_CYCLES(2)) DUT (.clock_in(clock_in), .rst_n_in(rst_n), .wb_cyc_in(cyc),
        .wb_stb_in(cyc), .wb_we_in(wr), .wb_adr_in(adr), .wb_sel_in(4'hf), .wb_dat_in(dat),
        .wb_dat_out(rdat), .wb_ack_out(ack), .key_press_in(kp), .key_start_in(ks),
        .key_arrow_in(1'h0), .key_rate_dir_in(rd), .key_held_in(1'h0), .key_accept_out(kacc),
        .stall_in(stall), .volume_step_in(vol), .power_was_running_in(1'h0),
        .motor_run_out(mrun), .motor_withdraw_out(mwd), .trigger_in(ttl[0]),
        .direction_in(ttl[1]), .motor_operating_out(mop), .pumping_led_out(led),
        .buzzer_out(buz), .alarm_msg_out(amsg), .setup_item_out(item), .phase_out(ph));
    task stop_test;
        $display("tests %0d errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : stop_test
    // one classic cycle; a read notes {mask, expected}
    task bus(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [31:0] m);
        @(posedge clock_in);
        cyc <= 1'h1;
        wr <= w;
        adr <= {a, 2'h0};
        dat <= d;
        if (!w) exp_q.push_back({m, d});
        do @(posedge clock_in); while (ack !== 1'h1);
        cyc <= 1'h0;
    endtask : bus
    // settled outputs under a mask
    task chk(input logic [16:0] m, input logic [16:0] x);
        @(negedge clock_in);
        n_tests++;
        if ((o & m) !== x) begin
            n_errors++;
            $display("wrong value outputs exp %h seen %h", x, o & m);
        end
    endtask : chk
    task key(input logic s);
        @(posedge clock_in);
        kp <= 1'h1;
        ks <= s;
        @(posedge clock_in);
        kp <= 1'h0;
    endtask : key
    // read results taken off the queue
    always @(negedge clock_in) begin
        if (ack === 1'h1 && !wr) begin
            e = exp_q.pop_front();
            n_tests++;
            if ((rdat & e[63:32]) !== e[31:0]) begin
                n_errors++;
                $display("wrong value reg %0h exp %h seen %h", adr, e[31:0], rdat & e[63:32]);
            end
        end
    end
    always @(posedge clock_in) begin
        vol <= 1'($random(seed));
        cycles++;
        if (cycles == 4000) begin
            n_errors++;
            stop_test;
        end
    end
    initial begin
        repeat (3) @(posedge clock_in);
        rst_n <= 1'h1;
        bus(0, `ADR_SETUP, `SETUP_RESET, 32'hffffffff);
        bus(0, 4'h8, 32'h0, 32'hffffffff);
        bus(1, `ADR_SETUP, 32'h62, 0);
        chk(17'h007c0, 17'h00040);
        repeat (7) @(posedge clock_in);
        chk(17'h007c0, 17'h000c0);
        bus(1, `ADR_PHASE_SEL, 32'h1, 0);
        bus(1, `ADR_PHASE_DATA, 32'h0, 0);
        bus(1, `ADR_CTRL, 32'h1, 0);
        bus(0, `ADR_STATUS, 32'h101, 32'h3f07);
        chk(17'h1ffff, 17'h00f93);
        bus(1, `ADR_CTRL, 32'h2, 0);
        bus(0, `ADR_STATUS, 32'h103, 32'h3f07);
        bus(1, `ADR_CTRL, 32'h5, 0);
        bus(0, `ADR_STATUS, 32'h101, 32'h3f07);
        stall <= 1'h1;
        @(posedge clock_in);
        chk(17'h00005, 17'h00004);
        repeat (2) @(posedge clock_in);
        stall <= 1'h0;
        chk(17'h0000f, 17'h00008);
        bus(0, `ADR_STATUS, 32'h107, 32'h3f07);
        key(1'h1);
        bus(0, `ADR_STATUS, 32'h101, 32'h3f07);
        bus(1, `ADR_CTRL, 32'h2, 0);
        key(1'h0);
        bus(0, `ADR_STATUS, 32'h100, 32'h3f07);
        go <= 2'h3;
        @(posedge clock_in);
        go <= 2'h0;
        repeat (12) @(posedge clock_in);
        bus(0, `ADR_STATUS, 32'h101, 32'h3f07);
        chk(17'h00020, 17'h00020);
        bus(1, `ADR_CTRL, 32'h2, 0);
        key(1'h0);
        ad = {16'h0, 8'($unsigned($random(seed)) % 100), 8'h0};
        bus(1, `ADR_SETUP, ad, 0);
        bus(1, `ADR_SETUP, 32'h6400, 0);
        bus(0, `ADR_SETUP, ad, 32'hff00);
        bus(1, `ADR_PHASE_DATA, 32'h8000002a, 0);
        bus(1, `ADR_CTRL, 32'h1, 0);
        repeat (4) @(posedge clock_in);
        bus(0, `ADR_STATUS, 32'h8, 32'hf);
        chk(17'h1f803, 17'h00800);
        repeat (3) @(posedge clock_in);
        stop_test;
    end
endmodule : testbench
`default_nettype wire
